// file: rtl/ccs_i2c_slave.sv
// Serial register port slave with auto-incrementing register pointer
`timescale 1ns/1ps
module ccs_i2c_slave #(
	parameter logic [6:0] ADDR = ccs_pkg::I2C_ADDR
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	output logic wr_stb,
	output logic rd_stb,
	output logic [7:0] reg_addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	typedef enum logic [6:0] {
		CI_IDLE = 7'h01, CI_ADDR = 7'h02, CI_PTR = 7'h04, CI_WDATA = 7'h08,
		CI_ACK = 7'h10, CI_RDATA = 7'h20, CI_MACK = 7'h40
	} ccs_i2c_st_t;

	ccs_i2c_st_t st_reg, st_next, ret_reg, ret_next;
	logic scl_reg, sda_reg, oe_next, wr_next, rd_next, inc_reg, inc_next;
	logic [7:0] sh_reg, sh_next, ptr_next, wd_next;
	logic [3:0] cnt_reg, cnt_next;
	logic start, stop, rise, fall;

	assign start = scl_in & scl_reg & sda_reg & ~sda_in;
	assign stop = scl_in & scl_reg & ~sda_reg & sda_in;
	assign rise = scl_in & ~scl_reg;
	assign fall = ~scl_in & scl_reg;

	always_comb
	begin
		st_next = st_reg;
		ret_next = ret_reg;
		oe_next = sda_oe;
		wr_next = 1'b0;
		rd_next = 1'b0;
		inc_next = inc_reg;
		sh_next = sh_reg;
		ptr_next = reg_addr;
		wd_next = wdata;
		cnt_next = cnt_reg;
		if (start)
		begin
			st_next = CI_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end
		else if (stop)
		begin
			st_next = CI_IDLE;
			oe_next = 1'b0;
		end
		else
		begin
			case (st_reg)
				CI_ADDR, CI_PTR, CI_WDATA:
				begin
					if (rise)
					begin
						sh_next = {sh_reg[6:0], sda_in};
						cnt_next = cnt_reg + 4'h1;
					end
					if (fall && cnt_reg == 4'h8)
					begin
						cnt_next = 4'h0;
						oe_next = 1'b1;
						st_next = CI_ACK;
						inc_next = 1'b0;
						if (st_reg == CI_ADDR)
						begin
							ret_next = sh_reg[0] ? CI_RDATA : CI_PTR;
							if (sh_reg[7:1] != ADDR)
							begin
								oe_next = 1'b0;
								st_next = CI_IDLE;
							end
						end
						else if (st_reg == CI_PTR)
						begin
							ptr_next = sh_reg;
							ret_next = CI_WDATA;
						end
						else
						begin
							wd_next = sh_reg;
							wr_next = 1'b1;
							inc_next = 1'b1;
							ret_next = CI_WDATA;
						end
					end
				end
				CI_ACK, CI_MACK:
				begin
					if (rise && st_reg == CI_MACK && sda_in)
						st_next = CI_IDLE;
					else if (fall)
					begin
						oe_next = 1'b0;
						st_next = ret_reg;
						if (inc_reg)
							ptr_next = reg_addr + 8'h1;
						if (ret_reg == CI_RDATA)
						begin
							sh_next = {rdata[6:0], 1'b0};
							oe_next = ~rdata[7];
							rd_next = 1'b1;
							cnt_next = 4'h1;
						end
					end
				end
				CI_RDATA:
				begin
					if (rise && cnt_reg == 4'h8)
						ptr_next = reg_addr + 8'h1;
					if (fall)
					begin
						if (cnt_reg == 4'h8)
						begin
							oe_next = 1'b0;
							st_next = CI_MACK;
							ret_next = CI_RDATA;
							inc_next = 1'b0;
						end
						else
						begin
							oe_next = ~sh_reg[7];
							sh_next = {sh_reg[6:0], 1'b0};
							cnt_next = cnt_reg + 4'h1;
						end
					end
				end
				default:
					st_next = CI_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= CI_IDLE;
			ret_reg <= CI_IDLE;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			inc_reg <= 1'b0;
			sh_reg <= 8'h00;
			reg_addr <= 8'h00;
			wdata <= 8'h00;
			cnt_reg <= 4'h0;
		end
		else
		begin
			st_reg <= st_next;
			ret_reg <= ret_next;
			scl_reg <= scl_in;
			sda_reg <= sda_in;
			sda_oe <= oe_next;
			wr_stb <= wr_next;
			rd_stb <= rd_next;
			inc_reg <= inc_next;
			sh_reg <= sh_next;
			reg_addr <= ptr_next;
			wdata <= wd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// file: rtl/ccs_pkg.sv
// Shared constants and carrier types of the charge cycle sequencer
package ccs_pkg;
	// Register map
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] SUPPLY_OFS = 8'h01;
	localparam logic [7:0] CTRL_OFS = 8'h02;
	localparam logic [7:0] VREG_OFS = 8'h03;
	// Control register fields
	localparam int RESET_BIT = 7;
	localparam int TE_BIT = 2;
	localparam int CE_N_BIT = 1;
	localparam int HIZ_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h04;
	// Regulation voltage: 3.5 V plus 20 mV per code, code in bits 7:2
	localparam int VREG_LSB = 2;
	localparam logic [5:0] VREG_RESET = 6'h05;
	localparam logic [5:0] VREG_MAX = 6'h2f;
	// Fault field codes
	localparam logic [2:0] FAULT_NORMAL = 3'h0;
	localparam logic [2:0] FAULT_BAT_OVP = 3'h1;
	localparam logic [2:0] FAULT_NO_BAT = 3'h2;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int PULSE_NS = 128_000;
	localparam int PULSE_CYC = PULSE_NS / CLK_NS;
	localparam int OVP_DGL_US = 1000;
	localparam int OVP_DGL_CYC = (OVP_DGL_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int DETECT_CYC = 1000;
	localparam int SHORT_DGL_CYC = 200;
	localparam int SHORT_REC_CYC = 2000;
	// Serial address, arbitrary value
	localparam logic [6:0] I2C_ADDR = 7'h2a;

	typedef struct packed {
		logic supply_valid;
		logic sys_above_reg;
		logic cv_phase;
		logic at_term;
		logic above_recharge;
		logic above_detect;
		logic bat_ovp;
		logic sys_at_min;
		logic chg_zero;
		logic load_rising;
		logic short_limit;
		logic below_uvlo;
	} ccs_sense_t;

	typedef struct packed {
		logic converter_on;
		logic fet_full;
		logic fet_linear;
		logic charge_on;
		logic full_current;
		logic current_reduce;
		logic supplement;
		logic sink_on;
		logic source_on;
	} ccs_drive_t;
endpackage

// file: rtl/ccs_top.sv
// Charge cycle sequencer: charge, termination, detection, power path, faults
//
// Functional notes
// - Charging above system level, battery path full on
// - Regulation target programmable, 3.5V to 4.44V
// - Taper plus recharge level ends charge, detect
// - Termination bit 0 disables termination and detection
// - Recharge, supply, enable, reset, high-impedance restart charging
// - Sink test current one interval, then done
// - Sink voltage drop flags battery absent fault
// - Source short current one interval, then sink
// - Detection repeats; found battery clears fault, recharges
// - New supply: pulse, fault normal, supply flagged
// - Enable bit 1 of 0x02, active low
// - Enable bit high: path off, system regulated
// - Sagging system reduces current, then supplement mode
// - Overvoltage stops converter, path on to discharge
// - Overvoltage lasting deglitch reports fault
// - Overvoltage fault clears on recharge level, high-impedance
// - Battery-only short: path off, recover, retry
// - Battery-only undervoltage keeps battery path off
`timescale 1ns/1ps
module ccs_top #(
	parameter int DETECT_CYC = ccs_pkg::DETECT_CYC,
	parameter int SHORT_DGL_CYC = ccs_pkg::SHORT_DGL_CYC,
	parameter int SHORT_REC_CYC = ccs_pkg::SHORT_REC_CYC,
	parameter int OVP_DGL_CYC = ccs_pkg::OVP_DGL_CYC,
	parameter logic [6:0] I2C_ADDR = ccs_pkg::I2C_ADDR
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire ccs_pkg::ccs_sense_t sense,
	input wire logic chip_disable_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output ccs_pkg::ccs_drive_t drive,
	output logic stat_int,
	output logic [5:0] battery_regulation_voltage
);
	typedef enum logic [7:0] {
		CS_NO_INPUT = 8'h01, CS_SHORT = 8'h02, CS_HIZ = 8'h04, CS_STANDBY = 8'h08,
		CS_CHARGE = 8'h10, CS_SINK = 8'h20, CS_SOURCE = 8'h40, CS_DONE = 8'h80
	} ccs_state_t;

	function automatic logic [2:0] ccs_code(input ccs_state_t s);
		case (s)
			CS_NO_INPUT: ccs_code = 3'h0;
			CS_SHORT: ccs_code = 3'h1;
			CS_HIZ: ccs_code = 3'h2;
			CS_STANDBY: ccs_code = 3'h3;
			CS_CHARGE: ccs_code = 3'h4;
			CS_SINK: ccs_code = 3'h5;
			CS_SOURCE: ccs_code = 3'h6;
			default: ccs_code = 3'h7;
		endcase
	endfunction

	ccs_state_t st_reg, st_next;
	ccs_pkg::ccs_drive_t drive_next;
	logic [15:0] tmr_reg, tmr_next;
	logic [15:0] ovp_reg, ovp_next;
	logic [11:0] pls_reg, pls_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [5:0] vreg_next;
	logic [2:0] fault_reg, fault_next;
	logic new_sup_reg, new_sup_next;
	logic sup_prev_reg, ce_prev_reg, hiz_prev_reg;
	logic stat_next;
	logic wr_stb, rd_stb;
	logic [7:0] reg_addr, wdata, rdata;
	logic te, ce_n, hiz_on, sup_rise, restart, supplement;

	ccs_i2c_slave #(
		.ADDR(I2C_ADDR)
	) u_port (
		.clock(clock),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.reg_addr(reg_addr),
		.wdata(wdata),
		.rdata(rdata)
	);

	assign te = ctrl_reg[ccs_pkg::TE_BIT];
	assign ce_n = ctrl_reg[ccs_pkg::CE_N_BIT];
	assign hiz_on = ctrl_reg[ccs_pkg::HIZ_BIT] | chip_disable_pin;
	assign sup_rise = sense.supply_valid & ~sup_prev_reg;
	assign restart = sup_rise | (ce_n != ce_prev_reg) | ctrl_reg[ccs_pkg::RESET_BIT]
		| (ctrl_reg[ccs_pkg::HIZ_BIT] != hiz_prev_reg);
	assign supplement = sense.supply_valid & ~hiz_on & sense.sys_at_min
		& sense.chg_zero & sense.load_rising;

	////////////////////////////////////////////////////////////////////////////
	// Register file
	always_comb
	begin
		case (reg_addr)
			ccs_pkg::STATUS_OFS: rdata = {2'b00, ccs_code(st_reg), fault_reg};
			ccs_pkg::SUPPLY_OFS: rdata = {6'h00, sense.supply_valid, new_sup_reg};
			ccs_pkg::CTRL_OFS: rdata = ctrl_reg;
			ccs_pkg::VREG_OFS: rdata = {battery_regulation_voltage, 2'b00};
			default: rdata = 8'h00;
		endcase
	end

	always_comb
	begin
		ctrl_next = ctrl_reg;
		ctrl_next[ccs_pkg::RESET_BIT] = 1'b0;
		vreg_next = battery_regulation_voltage;
		if (wr_stb && reg_addr == ccs_pkg::CTRL_OFS)
			ctrl_next = wdata;
		if (wr_stb && reg_addr == ccs_pkg::VREG_OFS)
		begin
			vreg_next = wdata[7:ccs_pkg::VREG_LSB];
			if (vreg_next > ccs_pkg::VREG_MAX)
				vreg_next = ccs_pkg::VREG_MAX;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= ccs_pkg::CTRL_RESET;
			battery_regulation_voltage <= ccs_pkg::VREG_RESET;
			sup_prev_reg <= 1'b0;
			ce_prev_reg <= ccs_pkg::CTRL_RESET[ccs_pkg::CE_N_BIT];
			hiz_prev_reg <= ccs_pkg::CTRL_RESET[ccs_pkg::HIZ_BIT];
			sda_out <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			battery_regulation_voltage <= vreg_next;
			sup_prev_reg <= sense.supply_valid;
			ce_prev_reg <= ce_n;
			hiz_prev_reg <= ctrl_reg[ccs_pkg::HIZ_BIT];
			sda_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Charge sequence
	always_comb
	begin
		st_next = st_reg;
		tmr_next = tmr_reg + 16'h1;
		if (!sense.supply_valid)
		begin
			if (st_reg == CS_SHORT)
			begin
				if (tmr_reg == 16'(SHORT_DGL_CYC + SHORT_REC_CYC - 1))
					st_next = CS_NO_INPUT;
			end
			else if (sense.short_limit && !sense.below_uvlo)
			begin
				st_next = CS_SHORT;
				tmr_next = 16'h0;
			end
			else
				st_next = CS_NO_INPUT;
		end
		else if (hiz_on)
			st_next = CS_HIZ;
		else if (ce_n)
			st_next = CS_STANDBY;
		else if (restart || st_reg == CS_NO_INPUT || st_reg == CS_SHORT
			|| st_reg == CS_HIZ || st_reg == CS_STANDBY)
			st_next = CS_CHARGE;
		else
		begin
			case (st_reg)
				CS_CHARGE:
				begin
					if (te && sense.cv_phase && sense.at_term && sense.above_recharge)
					begin
						st_next = CS_SINK;
						tmr_next = 16'h0;
					end
				end
				CS_SINK:
				begin
					if (!te)
						st_next = CS_CHARGE;
					else if (!sense.above_detect)
					begin
						st_next = CS_SOURCE;
						tmr_next = 16'h0;
					end
					else if (tmr_reg == 16'(DETECT_CYC - 1))
						st_next = (fault_reg == ccs_pkg::FAULT_NO_BAT) ? CS_CHARGE : CS_DONE;
				end
				CS_SOURCE:
				begin
					if (!te)
						st_next = CS_CHARGE;
					else if (tmr_reg == 16'(DETECT_CYC - 1))
					begin
						st_next = CS_SINK;
						tmr_next = 16'h0;
					end
				end
				CS_DONE:
				begin
					if (!sense.above_recharge)
						st_next = CS_CHARGE;
				end
				default:
					st_next = CS_CHARGE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Faults, supply status and host pulse
	always_comb
	begin
		fault_next = fault_reg;
		new_sup_next = new_sup_reg;
		pls_next = pls_reg;
		stat_next = 1'b0;
		ovp_next = sense.bat_ovp ? ovp_reg : 16'h0;
		if (sense.bat_ovp && ovp_reg != 16'(OVP_DGL_CYC))
			ovp_next = ovp_reg + 16'h1;
		if (pls_reg != 12'h0)
		begin
			pls_next = pls_reg - 12'h1;
			stat_next = 1'b1;
		end
		if (rd_stb && reg_addr == ccs_pkg::SUPPLY_OFS)
			new_sup_next = 1'b0;
		if (fault_reg == ccs_pkg::FAULT_BAT_OVP && (!sense.above_recharge || hiz_on))
			fault_next = ccs_pkg::FAULT_NORMAL;
		if (st_reg == CS_SINK && st_next == CS_CHARGE && sense.above_detect)
			fault_next = ccs_pkg::FAULT_NORMAL;
		if (st_reg == CS_SINK && st_next == CS_SOURCE)
			fault_next = ccs_pkg::FAULT_NO_BAT;
		if (sup_rise)
		begin
			fault_next = ccs_pkg::FAULT_NORMAL;
			new_sup_next = 1'b1;
			pls_next = 12'(ccs_pkg::PULSE_CYC - 1);
			stat_next = 1'b1;
		end
		if (ovp_reg == 16'(OVP_DGL_CYC - 1) && sense.bat_ovp)
			fault_next = ccs_pkg::FAULT_BAT_OVP;
	end

	////////////////////////////////////////////////////////////////////////////
	// Power path drive
	always_comb
	begin
		drive_next = '0;
		drive_next.supplement = supplement;
		drive_next.converter_on = sense.supply_valid & ~hiz_on & ~sense.bat_ovp;
		case (st_next)
			CS_NO_INPUT:
				drive_next.fet_full = ~sense.below_uvlo;
			CS_CHARGE:
			begin
				drive_next.fet_full = sense.sys_above_reg;
				drive_next.fet_linear = ~sense.sys_above_reg;
				drive_next.charge_on = ~supplement;
				drive_next.full_current = sense.sys_above_reg & ~sense.sys_at_min;
				drive_next.current_reduce = sense.sys_at_min;
			end
			CS_SINK:
				drive_next.sink_on = 1'b1;
			CS_SOURCE:
				drive_next.source_on = ~sense.above_detect;
			default:
				drive_next.fet_full = 1'b0;
		endcase
		if (supplement)
			drive_next.fet_full = 1'b1;
		if (sense.bat_ovp && sense.supply_valid)
		begin
			drive_next.fet_full = 1'b1;
			drive_next.charge_on = 1'b0;
			drive_next.fet_linear = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= CS_NO_INPUT;
			tmr_reg <= 16'h0;
			ovp_reg <= 16'h0;
			pls_reg <= 12'h0;
			fault_reg <= ccs_pkg::FAULT_NORMAL;
			new_sup_reg <= 1'b0;
			stat_int <= 1'b0;
			drive <= '0;
		end
		else
		begin
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			ovp_reg <= ovp_next;
			pls_reg <= pls_next;
			fault_reg <= fault_next;
			new_sup_reg <= new_sup_next;
			stat_int <= stat_next;
			drive <= drive_next;
		end
	end
endmodule

// file: sim/ccs_chk.sv
// Port-level assertions for the charge cycle sequencer
`timescale 1ns/1ps
module ccs_chk #(
	parameter int DETECT_CYC = ccs_pkg::DETECT_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire ccs_pkg::ccs_sense_t sense,
	input wire logic chip_disable_pin,
	input wire ccs_pkg::ccs_drive_t drive,
	input wire logic stat_int,
	input wire logic [5:0] battery_regulation_voltage
);
	int pulse_cnt_reg;
	int pulse_cnt_next;
	int sink_cnt_reg;
	int sink_cnt_next;

	// Lengths of the status pulse and of the sink phase so far
	always_comb
	begin
		pulse_cnt_next = stat_int ? pulse_cnt_reg + 1 : 0;
		sink_cnt_next = drive.sink_on ? sink_cnt_reg + 1 : 0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_cnt_reg <= 0;
			sink_cnt_reg <= 0;
		end
		else
		begin
			pulse_cnt_reg <= pulse_cnt_next;
			sink_cnt_reg <= sink_cnt_next;
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_vreg_in_range: assert property (
		battery_regulation_voltage <= ccs_pkg::VREG_MAX) else $error("vreg code out of range");
	a_supply_pulse: assert property (
		$rose(sense.supply_valid) |-> ##[1:2] stat_int) else $error("no pulse on new supply");
	a_pulse_width: assert property (
		$fell(stat_int) |-> pulse_cnt_reg == ccs_pkg::PULSE_CYC) else $error("pulse width");
	a_ovp_stop: assert property (
		sense.supply_valid && sense.bat_ovp |=> !drive.converter_on && drive.fet_full)
		else $error("overvoltage not stopped");
	a_uvlo_path_off: assert property (
		!sense.supply_valid && sense.below_uvlo |=> !drive.fet_full) else $error("uvlo path on");
	a_short_retry: assert property (
		!sense.supply_valid && !sense.below_uvlo && sense.short_limit && drive.fet_full
		|=> !drive.fet_full [*8] ##[1:4] drive.fet_full) else $error("short retry timing");
	a_sink_bound: assert property (
		sink_cnt_reg <= DETECT_CYC) else $error("sink phase too long");
	a_sink_fail: assert property (
		drive.sink_on && !sense.above_detect |-> ##[1:2] (drive.source_on && !drive.sink_on))
		else $error("no source after failed sink");
	a_supplement_on: assert property (
		sense.supply_valid && !chip_disable_pin && sense.sys_at_min && sense.chg_zero
		&& sense.load_rising |=> drive.supplement && drive.fet_full) else $error("no supplement");
endmodule

bind ccs_top ccs_chk #(.DETECT_CYC(DETECT_CYC)) u_ccs_chk (
	.clock,
	.rst_n,
	.sense,
	.chip_disable_pin,
	.drive,
	.stat_int,
	.battery_regulation_voltage
);

// file: sim/ccs_host_model.sv
// Host serial master model driving the open-drain register port
`timescale 1ns/1ps
module ccs_host_model (
	input wire logic clock,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic pull = 1'b0;
	// Pulled-up data wire, low while either side pulls
	assign sda = !(pull || sda_oe === 1'b1);
	initial scl = 1'b1;

	task automatic q(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		q(4);
		scl = 1'b1;
		q(4);
		r = sda;
		scl = 1'b0;
		q(2);
	endtask

	task automatic start;
		pull = 1'b0;
		scl = 1'b1;
		q(4);
		pull = 1'b1;
		q(4);
		scl = 1'b0;
		q(2);
	endtask

	task automatic stop;
		pull = 1'b1;
		q(4);
		scl = 1'b1;
		q(4);
		pull = 1'b0;
		q(4);
	endtask

	// Ninth bit is released so the device may acknowledge
	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'b1, a);
		ack = !a;
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] o, d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start();
		xfer({dev, 1'b0}, r, a0);
		xfer(o, r, a1);
		xfer(d, r, a2);
		stop();
		ok = a0 && a1 && a2;
	endtask

	task automatic read_reg(input logic [7:0] o, output logic [7:0] d);
		logic [7:0] r;
		logic a;
		start();
		xfer({ccs_pkg::I2C_ADDR, 1'b0}, r, a);
		xfer(o, r, a);
		stop();
		start();
		xfer({ccs_pkg::I2C_ADDR, 1'b1}, r, a);
		xfer(8'hff, d, a);
		stop();
	endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the charge cycle sequencer
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	ccs_pkg::ccs_sense_t sense = '0;
	ccs_pkg::ccs_drive_t drive;
	logic scl, sda, sda_out, sda_oe, stat_int, ok;
	logic chip_disable_pin = 1'b0;
	logic [5:0] vreg;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	always #25 clock = ~clock;

	ccs_top #(.SHORT_DGL_CYC(5), .SHORT_REC_CYC(5), .OVP_DGL_CYC(20)) u_ccs_top (
		.clock, .rst_n, .sense, .chip_disable_pin, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe, .drive, .stat_int, .battery_regulation_voltage(vreg)
	);

	ccs_host_model host (.clock, .sda_oe, .scl, .sda);

	////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %0s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rd(input logic [7:0] o, m, e);
		logic [7:0] d;
		host.read_reg(o, d);
		chk($sformatf("reg %h", o), e, d & m);
	endtask

	task automatic st(input logic [7:0] e);
		rd(8'h00, 8'hff, e);
	endtask

	task automatic wr(input logic [7:0] o, d);
		host.write_reg(ccs_pkg::I2C_ADDR, o, d, ok);
		chk("ack", 8'h01, {7'h00, ok});
	endtask

	task automatic done(input string n);
		$display("test %0s done", n);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////
	initial
	begin
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
		sense.below_uvlo = 1'b1;
		cyc(2);
		chk("fet_full", 8'h00, {7'h00, drive.fet_full});
		sense.below_uvlo = 1'b0;
		cyc(2);
		chk("fet_full", 8'h01, {7'h00, drive.fet_full});
		sense.short_limit = 1'b1;
		cyc(2);
		chk("fet_full", 8'h00, {7'h00, drive.fet_full});
		sense.short_limit = 1'b0;
		cyc(12);
		chk("fet_full", 8'h01, {7'h00, drive.fet_full});
		done("battery only");
		rd(8'h02, 8'hff, ccs_pkg::CTRL_RESET);
		rd(8'h03, 8'hff, {ccs_pkg::VREG_RESET, 2'b00});
		chk("vreg", {2'b00, ccs_pkg::VREG_RESET}, {2'b00, vreg});
		rd(8'h07, 8'hff, 8'h00);
		host.write_reg(7'h11, 8'h02, 8'h00, ok);
		chk("nack", 8'h00, {7'h00, ok});
		st(8'h00);
		done("registers");
		sense.supply_valid = 1'b1;
		sense.sys_above_reg = 1'b1;
		sense.above_detect = 1'b1;
		cyc(2);
		chk("stat_int", 8'h01, {7'h00, stat_int});
		rd(8'h01, 8'hff, 8'h03);
		rd(8'h01, 8'hff, 8'h02);
		st(8'h20);
		chk("fet_full", 8'h01, {7'h00, drive.fet_full});
		chk("full_current", 8'h01, {7'h00, drive.full_current});
		chk("charge_on", 8'h01, {7'h00, drive.charge_on});
		chk("sda_out", 8'h00, {7'h00, sda_out});
		sense.sys_above_reg = 1'b0;
		cyc(2);
		chk("fet_linear", 8'h01, {7'h00, drive.fet_linear});
		chk("full_current", 8'h00, {7'h00, drive.full_current});
		sense.sys_above_reg = 1'b1;
		cyc(2);
		done("supply");
		wr(8'h02, 8'h06);
		st(8'h18);
		chk("fet_full", 8'h00, {7'h00, drive.fet_full});
		wr(8'h02, 8'h04);
		st(8'h20);
		wr(8'h02, 8'h84);
		rd(8'h02, 8'hff, 8'h04);
		st(8'h20);
		done("enable");
		wr(8'h02, 8'h00);
		sense.cv_phase = 1'b1;
		sense.at_term = 1'b1;
		sense.above_recharge = 1'b1;
		cyc(4);
		chk("sink_on", 8'h00, {7'h00, drive.sink_on});
		st(8'h20);
		sense.above_recharge = 1'b0;
		wr(8'h02, 8'h04);
		done("no termination");
		sense.above_recharge = 1'b1;
		cyc(3);
		chk("sink_on", 8'h01, {7'h00, drive.sink_on});
		st(8'h28);
		cyc(1000);
		st(8'h38);
		sense.above_recharge = 1'b0;
		cyc(2);
		st(8'h20);
		done("detection");
		sense.above_recharge = 1'b1;
		cyc(3);
		sense.above_detect = 1'b0;
		cyc(3);
		chk("source_on", 8'h01, {7'h00, drive.source_on});
		st(8'h32);
		sense.above_detect = 1'b1;
		cyc(2);
		chk("source_on", 8'h00, {7'h00, drive.source_on});
		cyc(1000);
		chk("sink_on", 8'h01, {7'h00, drive.sink_on});
		sense.at_term = 1'b0;
		cyc(1000);
		st(8'h20);
		done("no battery");
		sense.sys_at_min = 1'b1;
		cyc(2);
		chk("current_reduce", 8'h01, {7'h00, drive.current_reduce});
		sense.chg_zero = 1'b1;
		sense.load_rising = 1'b1;
		cyc(2);
		chk("supplement", 8'h01, {7'h00, drive.supplement});
		sense.sys_at_min = 1'b0;
		sense.chg_zero = 1'b0;
		sense.load_rising = 1'b0;
		done("supplement");
		sense.bat_ovp = 1'b1;
		cyc(10);
		sense.bat_ovp = 1'b0;
		rd(8'h00, 8'h07, 8'h00);
		sense.bat_ovp = 1'b1;
		cyc(2);
		chk("converter_on", 8'h00, {7'h00, drive.converter_on});
		cyc(30);
		rd(8'h00, 8'h07, 8'h01);
		sense.bat_ovp = 1'b0;
		sense.above_recharge = 1'b0;
		cyc(2);
		rd(8'h00, 8'h07, 8'h00);
		sense.above_recharge = 1'b1;
		sense.bat_ovp = 1'b1;
		cyc(30);
		sense.bat_ovp = 1'b0;
		wr(8'h02, 8'h05);
		st(8'h10);
		wr(8'h03, 8'hbc);
		chk("vreg", 8'h2f, {2'b00, vreg});
		wr(8'h03, 8'hfc);
		rd(8'h03, 8'hff, 8'hbc);
		wr(8'h02, 8'h04);
		st(8'h20);
		sense.bat_ovp = 1'b1;
		cyc(30);
		sense.bat_ovp = 1'b0;
		rd(8'h00, 8'h07, 8'h01);
		chip_disable_pin = 1'b1;
		cyc(2);
		st(8'h10);
		chip_disable_pin = 1'b0;
		cyc(2);
		st(8'h20);
		done("overvoltage");
		end_of_test();
	end
endmodule
